// >>> design/ures_pkg.sv
// package of constants for the receive error status block
// assumes a byte-wide receiver on the same clock as the register port
package ures_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [15:0] URES_ERR_ADDR = 16'hFF73;
	localparam logic [15:0] URES_BUF_ADDR = 16'hFF72;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int URES_PAR_BIT = 2;
	localparam int URES_FRM_BIT = 1;
	localparam int URES_OVR_BIT = 0;
	localparam logic [2:0] URES_FLAGS_RST = 3'h0;
	localparam logic [4:0] URES_ZERO_HI = 5'h00;
	localparam logic [7:0] URES_BYTE_ZERO = 8'h00;

	// ****************************************
	// parity select encodings
	// ****************************************
	localparam logic [1:0] URES_PAR_NONE = 2'h0;
	localparam logic [1:0] URES_PAR_ZERO = 2'h1;
	localparam logic [1:0] URES_PAR_ODD = 2'h2;
	localparam logic [1:0] URES_PAR_EVEN = 2'h3;

	// read access sequencer
	typedef enum {URES_RD_IDLE, URES_RD_WAIT} ures_rd_e;

endpackage : ures_pkg

// >>> design/ures_chk_if.sv
// interface between the error block and its frame checker
// assumes both ends on the same clock, purely combinational link
`timescale 1ns/10ps
interface ures_chk_if #(
	parameter int DATA_W = 8
);
	logic [DATA_W-1:0] data;
	logic parity_in;
	logic stop_in;
	logic [1:0] parity_sel;
	logic parity_bad;
	logic stop_bad;

	modport judge (
		input data,
		input parity_in,
		input stop_in,
		input parity_sel,
		output parity_bad,
		output stop_bad
	);
	modport user (
		output data,
		output parity_in,
		output stop_in,
		output parity_sel,
		input parity_bad,
		input stop_bad
	);
endinterface : ures_chk_if

// >>> design/ures_frame_chk.sv
// frame checker: parity and first stop bit of one received character
// assumes inputs are stable while the character done pulse is high
`timescale 1ns/10ps
module ures_frame_chk
	import ures_pkg::*;
(
	ures_chk_if.judge chk
);

	// ****************************************
	// parity judgement per selected type
	// ****************************************
	logic odd_ones;

	// xor of data and received parity bit is one for an odd count
	always_comb
	begin
		odd_ones = (^chk.data) ^ chk.parity_in;
		unique case (chk.parity_sel)
			URES_PAR_ODD: chk.parity_bad = ~odd_ones;
			URES_PAR_EVEN: chk.parity_bad = odd_ones;
			URES_PAR_NONE, URES_PAR_ZERO: chk.parity_bad = 1'b0;
		endcase
	end

	// only the first stop position is looked at
	assign chk.stop_bad = ~chk.stop_in;

endmodule : ures_frame_chk

// >>> design/ures_top.sv
// receive error status register with its receive holding buffer
// assumes receiver shift logic and cpu port on clk, no pin synchronising
`timescale 1ns/10ps

// Functional notes
// - status byte: parity bit 2, framing bit 1, overrun bit 0, rest zero
// - reset or clearing power or receive enable bit zeroes the status
// - reading status returns flags, then clears parity and framing flags
// - parity mismatch at character end sets the parity flag
// - missing stop bit at character end sets the framing flag
// - character ending while buffer unread sets the overrun flag
// - on overrun the new character is dropped, buffer kept
// - framing check looks only at the first stop bit
// - parity judgement follows the two parity select bits
// - status is only read as a byte; writes do not change it
// - status read inserts one wait cycle; no reads with clock stopped
module ures_top
	import ures_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic serial_unit_power_bit,
	input wire logic receiver_enable_bit,
	input wire logic parity_select_high,
	input wire logic parity_select_low,
	input wire logic rx_char_done,
	input wire logic [DATA_W-1:0] rx_char_data,
	input wire logic rx_parity_in,
	input wire logic rx_stop_in,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	output logic rd_ack,
	output logic [7:0] rd_data,
	output logic [2:0] receive_error_flags,
	output logic rx_buffer_full
);

	// ****************************************
	// frame checker
	// ****************************************
	ures_chk_if #(.DATA_W(DATA_W)) chk_bus ();

	// hand the finished character to the checker
	assign chk_bus.data = rx_char_data;
	assign chk_bus.parity_in = rx_parity_in;
	assign chk_bus.stop_in = rx_stop_in;
	assign chk_bus.parity_sel = {parity_select_high, parity_select_low};

	// parity and first stop judgement, no state of its own
	ures_frame_chk u_chk (
		.chk(chk_bus)
	);

	// ****************************************
	// read sequencer
	// ****************************************
	ures_rd_e rd_state_r;
	ures_rd_e rd_state_nxt;
	logic [15:0] rd_addr_r;
	logic [15:0] rd_addr_nxt;
	logic rd_ack_r;
	logic rd_ack_nxt;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic err_read;
	logic buf_read;

	// ****************************************
	// flags and holding buffer
	// ****************************************
	logic [2:0] flags_r;
	logic [2:0] flags_nxt;
	logic [DATA_W-1:0] receive_holding_buffer_r;
	logic [DATA_W-1:0] receive_holding_buffer_nxt;
	logic full_r;
	logic full_nxt;
	logic rx_on;
	logic take_char;
	logic [7:0] status_byte;
	logic [7:0] buffer_byte;

	// ****************************************
	// access decode and status byte
	// ****************************************
	// receiver live only while both unit and receiver are on
	assign rx_on = serial_unit_power_bit & receiver_enable_bit;
	assign take_char = rx_char_done & rx_on;
	// upper bits always read as zero
	assign status_byte = {URES_ZERO_HI, flags_r};
	assign buffer_byte = 8'(receive_holding_buffer_r);
	// the access completes at the end of the wait cycle
	assign err_read = (rd_state_r == URES_RD_WAIT)
		&& (rd_addr_r == URES_ERR_ADDR);
	assign buf_read = (rd_state_r == URES_RD_WAIT)
		&& (rd_addr_r == URES_BUF_ADDR);

	// read request taken, one wait cycle, then registered answer
	always_comb
	begin
		// hold state and data, answer only from the wait cycle
		rd_state_nxt = rd_state_r;
		rd_addr_nxt = rd_addr_r;
		rd_ack_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		unique case (rd_state_r)
			URES_RD_IDLE:
			begin
				if (rd_req)
				begin
					rd_state_nxt = URES_RD_WAIT;
					rd_addr_nxt = rd_addr;
				end
			end
			URES_RD_WAIT:
			begin
				// a request arriving now is ignored
				rd_state_nxt = URES_RD_IDLE;
				rd_ack_nxt = 1'b1;
				// read only port, unmapped addresses answer zero
				if (err_read)
					rd_data_nxt = status_byte;
				else if (buf_read)
					rd_data_nxt = buffer_byte;
				else
					rd_data_nxt = URES_BYTE_ZERO;
			end
		endcase
	end

	// sequencer and answer registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rd_state_r <= URES_RD_IDLE;
			rd_addr_r <= 16'h0000;
			rd_ack_r <= 1'b0;
			rd_data_r <= URES_BYTE_ZERO;
		end
		else
		begin
			rd_state_r <= rd_state_nxt;
			rd_addr_r <= rd_addr_nxt;
			rd_ack_r <= rd_ack_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// ****************************************
	// flag and buffer update
	// ****************************************
	// a set in the clearing cycle wins
	always_comb
	begin
		// hold unless an event below changes it
		flags_nxt = flags_r;
		receive_holding_buffer_nxt = receive_holding_buffer_r;
		full_nxt = full_r;
		// clearing read of the status byte
		if (err_read)
		begin
			flags_nxt[URES_PAR_BIT] = 1'b0;
			flags_nxt[URES_FRM_BIT] = 1'b0;
		end
		// buffer read frees it and ends the overrun condition
		if (buf_read)
		begin
			full_nxt = 1'b0;
			flags_nxt[URES_OVR_BIT] = 1'b0;
		end
		// character end: judge it, then store or drop it
		if (take_char)
		begin
			if (chk_bus.parity_bad)
				flags_nxt[URES_PAR_BIT] = 1'b1;
			if (chk_bus.stop_bad)
				flags_nxt[URES_FRM_BIT] = 1'b1;
			// unread byte present: drop the new one
			if (full_r && !buf_read)
				flags_nxt[URES_OVR_BIT] = 1'b1;
			else
			begin
				receive_holding_buffer_nxt = rx_char_data;
				full_nxt = 1'b1;
			end
		end
		// unit or receiver switched off
		if (!rx_on)
			flags_nxt = URES_FLAGS_RST;
	end

	// flag, buffer and occupancy registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			flags_r <= URES_FLAGS_RST;
			receive_holding_buffer_r <= '0;
			full_r <= 1'b0;
		end
		else
		begin
			flags_r <= flags_nxt;
			receive_holding_buffer_r <= receive_holding_buffer_nxt;
			full_r <= full_nxt;
		end
	end

	// ****************************************
	// port outputs
	// ****************************************
	// outputs straight from flip-flops
	assign rd_ack = rd_ack_r;
	assign rd_data = rd_data_r;
	assign receive_error_flags = flags_r;
	assign rx_buffer_full = full_r;

endmodule : ures_top

// >>> dv/ures_top_asserts.sv
// checker: timing and flag properties seen at the top ports
// assumes bound into ures_top, one clock, srst synchronous
`timescale 1ns/10ps
module ures_top_asserts
	import ures_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic serial_unit_power_bit,
	input wire logic receiver_enable_bit,
	input wire logic parity_select_high,
	input wire logic parity_select_low,
	input wire logic rx_char_done,
	input wire logic [DATA_W-1:0] rx_char_data,
	input wire logic rx_parity_in,
	input wire logic rx_stop_in,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	input wire logic rd_ack,
	input wire logic [7:0] rd_data,
	input wire logic [2:0] receive_error_flags,
	input wire logic rx_buffer_full
);
	wire rx_on = serial_unit_power_bit && receiver_enable_bit;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// status read taken, no character during its wait cycle
	sequence st_rd;
		rd_req && rd_addr == URES_ERR_ADDR ##1 !rx_char_done;
	endsequence
	// character accepted by an enabled receiver
	sequence ch_in;
		rx_char_done && rx_on;
	endsequence
	AST_RD_FMT: assert property (
		rd_req && rd_addr == URES_ERR_ADDR |-> ##2 rd_ack && rd_data[7:3] == 5'h00)
		else $error("status read late or upper bits set");
	AST_RD_VAL: assert property (
		st_rd |=> rd_data[2:0] == $past(receive_error_flags))
		else $error("status read value differs from flags");
	AST_RD_CLR: assert property (
		st_rd |=> receive_error_flags[2:1] == 2'h0)
		else $error("parity or framing flag not cleared by read");
	AST_OFF: assert property (
		!rx_on |=> receive_error_flags == 3'h0)
		else $error("flags kept while receiver disabled");
	AST_FRM: assert property (
		ch_in ##0 !rx_stop_in |=> receive_error_flags[URES_FRM_BIT])
		else $error("framing flag not set");
	AST_PAR: assert property (
		ch_in ##0 parity_select_high
		&& (^{rx_char_data, rx_parity_in}) == parity_select_low
		|=> receive_error_flags[URES_PAR_BIT])
		else $error("parity flag not set");
	AST_OVR: assert property (
		ch_in ##0 rx_buffer_full && !$past(rd_req)
		|=> receive_error_flags[URES_OVR_BIT] && rx_buffer_full)
		else $error("overrun flag not set");
	AST_HOLD: assert property (
		receive_error_flags[URES_PAR_BIT] && rx_on && !$past(rd_req)
		|=> receive_error_flags[URES_PAR_BIT])
		else $error("parity flag dropped without a clear");
endmodule : ures_top_asserts
bind ures_top ures_top_asserts #(.DATA_W(DATA_W)) u_ures_top_asserts (
	.clk, .srst, .serial_unit_power_bit, .receiver_enable_bit,
	.parity_select_high, .parity_select_low, .rx_char_done, .rx_char_data,
	.rx_parity_in, .rx_stop_in, .rd_req, .rd_addr, .rd_ack, .rd_data,
	.receive_error_flags, .rx_buffer_full);

// >>> dv/ures_tx_model.sv
// remote transmitter model: hands one finished character per call
// assumes parity select shared with the block, lines scrambled when idle
`timescale 1ns/10ps
module ures_tx_model
	import ures_pkg::*;
(
	input wire logic clk,
	input wire logic [1:0] psel,
	output logic done,
	output logic [7:0] data,
	output logic par,
	output logic stop
);
	initial {done, data, par, stop} = 11'h000;
	// one character; bad_p flips parity, bad_s kills the first stop bit
	task send(input logic [7:0] d, input logic bad_p, input logic bad_s);
		@(posedge clk);
		#1 data = d;
		par = (psel[0] ? ^d : ~^d) ^ bad_p;
		stop = ~bad_s;
		done = 1'b1;
		@(posedge clk);
		#1 done = 1'b0;
		{data, par, stop} = ~{data, par, stop};
	endtask : send
endmodule : ures_tx_model

// >>> dv/tb_uart_rx_error_status.sv
// testbench: random characters with faults, status and buffer reads
// assumes the partner model and the bound checker
`timescale 1ns/10ps
module tb_uart_rx_error_status
	import ures_pkg::*;
;
	logic clk = 0, srst = 1, pw = 1, en = 1, rq = 0, bp, bs, pe, fe, oe, fu;
	logic [1:0] ps = 2'h0;
	logic [15:0] ad = 16'h0000;
	logic [7:0] v, be;
	wire done, par, stp, ack, full;
	wire [7:0] dat, rdat;
	wire [2:0] fl;
	int num_errors = 0, n_tests = 0, seed = 32'haf1e, i, j, n;
	// 8 ns period clock
	always #4 clk = ~clk;
	// far-side transmitter and the block under test
	ures_tx_model u_ures_tx_model (.clk, .psel(ps), .done, .data(dat), .par,
		.stop(stp));
	ures_top u_ures_top (.clk, .srst, .serial_unit_power_bit(pw),
		.receiver_enable_bit(en), .parity_select_high(ps[1]),
		.parity_select_low(ps[0]), .rx_char_done(done), .rx_char_data(dat),
		.rx_parity_in(par), .rx_stop_in(stp), .rd_req(rq), .rd_addr(ad),
		.rd_ack(ack), .rd_data(rdat), .receive_error_flags(fl),
		.rx_buffer_full(full));
	// compare one byte result
	task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// byte read: one-cycle request, bounded wait for the answer
	task rd(input logic [15:0] a, output logic [7:0] d);
		int k;
		@(posedge clk);
		#1 rq = 1'b1;
		ad = a;
		@(posedge clk);
		#1 rq = 1'b0;
		for (k = 0; k < 4 && ack !== 1'b1; k++) @(posedge clk) #1;
		cmp("ack", 8'h01, {7'h00, ack});
		d = rdat;
	endtask : rd
	// parity fault only counts for odd or even parity
	function logic perr(input logic [1:0] s, input logic b);
		return b & s[1];
	endfunction : perr
	// counts, verdict and end of run
	task close_out;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// watchdog sized well above the expected run
	initial
	begin
		#20000;
		num_errors++;
		close_out;
	end
	// main sequence
	initial
	begin
		{pe, fe, oe, fu, be} = 12'h000;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		rd(URES_ERR_ADDR, v);
		cmp("reset status", 8'h00, v);
		for (i = 0; i < 40; i++)
		begin
			ps = 2'($random(seed));
			n = (i < 4) ? 2 : 1 + ($random(seed) & 1);
			for (j = 0; j < n; j++)
			begin
				v = 8'($random(seed));
				bp = 1'($random(seed));
				bs = (i == 1) ? 1'b1 : 1'($random(seed));
				u_ures_tx_model.send(v, bp, bs);
				pe |= perr(ps, bp);
				fe |= bs;
				if (fu)
					oe = 1'b1;
				else
					{be, fu} = {v, 1'b1};
			end
			cmp("full", {7'h00, fu}, {7'h00, full});
			rd(URES_ERR_ADDR, v);
			cmp("status", {5'h00, pe, fe, oe}, v);
			{pe, fe} = 2'h0;
			cmp("flags", {5'h00, pe, fe, oe}, {5'h00, fl});
			rd(URES_BUF_ADDR, v);
			cmp("buffer", be, v);
			{fu, oe} = 2'h0;
			cmp("freed", 8'h00, {4'h0, fl, full});
			$display("test %0d done", i);
		end
		for (i = 0; i < 2; i++)
		begin
			ps = URES_PAR_EVEN;
			u_ures_tx_model.send(8'h5A, 1'b1, 1'b1);
			{pw, en} = i ? 2'h1 : 2'h2;
			@(posedge clk);
			#1 {pw, en} = 2'h3;
			rd(URES_ERR_ADDR, v);
			cmp("disabled status", 8'h00, v);
			rd(URES_BUF_ADDR, v);
			cmp("disabled buffer", 8'h5A, v);
			$display("disable test %0d done", i);
		end
		// mid-run reset with errors and an unread character pending
		u_ures_tx_model.send(8'hC3, 1'b1, 1'b1);
		cmp("pre reset flags", 8'h06, {5'h00, fl});
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		cmp("reset full", 8'h00, {7'h00, full});
		rd(URES_ERR_ADDR, v);
		cmp("mid reset status", 8'h00, v);
		$display("reset test done");
		rd(16'hFF70, v);
		cmp("unmapped", 8'h00, v);
		close_out;
	end
endmodule : tb_uart_rx_error_status
